// ===== src/ifc_flow_regs.vh
// Purpose: Constants for the in-band flow control block of one serial channel
// Assumes: 8-bit registers on a 32-bit AXI4-Lite word, low byte used
// Notes:   Offsets, commands and fill levels used by ifc_flow.v
//
// Contract
// - Mode field 00 host, 01 auto transmit, 10 auto receive, 11 both automatic.
// - Auto transmit: received pause lets current character finish, then transmitter stops.
// - Auto-stopped transmitter restarts only on resume or reset; reset flushes queue.
// - In auto transmit, transmitter commands have no effect.
// - While held idle the transmit queue keeps accepting writes and status.
// - Flow characters arriving on a full receive queue are ignored and not stored.
// - Strip bit 0 stores recognised flow characters, 1 discards error-free ones, any mode.
// - Recognition compares with resume and pause registers, customary 0x11 and 0x13.
// - Host pause command stops transmitter until reset or resume command 10110.
// - Host pause is not released by resume character or transmitter re-enable.
// - Auto receive sends pause above fill 240, resume below fill 16.
// - Inserted flow character follows shift register; queued data follows unchanged.
// - Flow character is dropped if its fill condition goes away before start.
// - Outstanding pause is tracked; mode 00 clears it; no resume on leaving.
// - Cancel-send drops pending host flow characters; ignored in automatic modes.
// - A flow character once loaded is never aborted except by reset.
// - Only recognition raises interrupts; transmitter actions raise none.
// - Comparators run in every mode, mode 00 included.
// - Recognition bids at bid register level, masked by bit 4, shown status bit 4.
// - Reset disables character recognition and its interrupt.
// - Flow characters with errors stay valid; error bits are stored as usual.
// - A zero flow character also matches the zero loaded on break.
// - Reset loads resume and pause registers with the standard characters.
// - Reading the flow status register clears its recognition bits.
`ifndef IFC_FLOW_REGS_VH
`define IFC_FLOW_REGS_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define IFC_MODE_REG_THREE  8'h00
`define IFC_COMMAND_REG     8'h04
`define IFC_RESUME_CHAR_REG 8'h08
`define IFC_PAUSE_CHAR_REG  8'h0c
`define IFC_FLOW_STATUS_REG 8'h10
`define IFC_IRQ_MASK_REG    8'h14
`define IFC_IRQ_STATUS_REG  8'h18
`define IFC_BID_CONTROL_REG 8'h1c

// ----------------------------------------------------------------
// Fields, codes and reset values
// ----------------------------------------------------------------
`define IFC_MODE_STRIP  7
`define IFC_MODE_RECOG  4
`define IFC_MODE_AUTORX 3
`define IFC_MODE_AUTOTX 2
`define IFC_MODE_RST    8'h00
`define IFC_CMD_TXEN    5'h02
`define IFC_CMD_TXDIS   5'h03
`define IFC_CMD_RESET   5'h04
`define IFC_CMD_PAUSE   5'h15
`define IFC_CMD_RESUME  5'h16
`define IFC_CMD_SENDON  5'h17
`define IFC_CMD_SENDOFF 5'h18
`define IFC_CMD_KILL    5'h19
`define IFC_RESUME_RST  8'h11
`define IFC_PAUSE_RST   8'h13
`define IFC_ST_RESUME   0
`define IFC_ST_PAUSE    1
`define IFC_IRQ_BIT     4
`define IFC_FILL_HIGH   9'h0f0
`define IFC_FILL_LOW    9'h010
`define IFC_RESP_OKAY   2'h0
`define IFC_RESP_SLVERR 2'h2

`endif

// ===== src/ifc_flow.v
// Purpose: In-band pause/resume flow control for one serial channel
// Assumes: Receiver, transmit queue and shift register sit outside this block
//          Shift register reports empty only when it can take a load
// Notes:   Registers on AXI4-Lite; the bid outputs feed an external arbiter
//          Flow characters skip the data hold, not a disabled sender
//
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`include "ifc_flow_regs.vh"

module ifc_flow (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        rxCharValid,
  input  wire [7:0]  rxChar,
  input  wire [2:0]  rxCharErr,
  input  wire        rxQueueFull,
  input  wire [8:0]  rxQueueFill,
  output reg         rxStoreValid,
  output reg  [7:0]  rxStoreChar,
  output reg  [2:0]  rxStoreErr,
  input  wire        txQueueValid,
  input  wire [7:0]  txQueueData,
  input  wire        txShiftEmpty,
  output reg         txQueuePop,
  output reg         txLoadValid,
  output reg  [7:0]  txLoadChar,
  output reg         txReset,
  output reg         recogBid,
  output reg  [2:0]  recogBidLevel
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Plain compare; a break delivers 8'h00 and matches a zero character
  // No break qualifier on purpose; avoid 8'h00 as a flow code
  function charHit;
    input [7:0] rcv;
    input [7:0] pat;
    begin
      charHit = (rcv == pat);
    end
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  // Write capture; address and data may arrive on different edges
  reg [7:0]  wrAddr_ff;
  reg [7:0]  wrData_ff;
  reg        wrStrb_ff;
  reg        awHeld_ff;
  reg        wHeld_ff;
  // Software visible control registers
  reg [7:0]  modeReg_ff;
  reg [7:0]  resumeChar_ff;
  reg [7:0]  pauseChar_ff;
  reg [4:0]  irqMask_ff;
  reg [2:0]  bidCtl_ff;
  // Flow state; auto and host stops have separate release paths
  reg [1:0]  recogSeen_ff;
  reg        txEnable_ff;
  reg        autoStop_ff;
  reg        hostStop_ff;
  reg        pauseOut_ff;
  // Host requests wait here until the shift register is free
  reg        hostSendOn_ff;
  reg        hostSendOff_ff;
  // Read mux outputs
  reg [7:0]  nxt_rdata;
  reg [1:0]  nxt_rresp;

  // Holding off on bvalid keeps a second write from overtaking
  wire       doWrite   = awHeld_ff & wHeld_ff & ~s_axi_bvalid;
  wire       wrMapped  = (wrAddr_ff[1:0] == 2'h0) & (wrAddr_ff <= `IFC_BID_CONTROL_REG);
  wire       regWrite  = doWrite & wrStrb_ff;
  wire       rdTake    = s_axi_arvalid & s_axi_arready;
  wire       cmdWrite  = regWrite & (wrAddr_ff == `IFC_COMMAND_REG);
  wire [4:0] cmdCode   = wrData_ff[7:3];
  wire       softReset = cmdWrite & (cmdCode == `IFC_CMD_RESET);
  // Flow mode decode; host mode is neither automatic direction
  wire       autoTx    = modeReg_ff[`IFC_MODE_AUTOTX];
  wire       autoRx    = modeReg_ff[`IFC_MODE_AUTORX];
  wire       hostMode  = ~autoTx & ~autoRx;
  wire       statusRd  = rdTake & (s_axi_araddr == `IFC_FLOW_STATUS_REG);

  // ----------------------------------------------------------------
  // AXI4-Lite slave handshakes
  // ----------------------------------------------------------------
  // Address and data are taken in either order; the write acts once both are held
  // Readies drop on take and rise after the response: one write in flight
  always @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `IFC_RESP_OKAY;
      awHeld_ff     <= 1'b0;
      wHeld_ff      <= 1'b0;
      wrAddr_ff     <= 8'h00;
      wrData_ff     <= 8'h00;
      wrStrb_ff     <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid & s_axi_awready)
      begin
        wrAddr_ff     <= s_axi_awaddr;
        awHeld_ff     <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready)
      begin
        wrData_ff    <= s_axi_wdata[7:0];
        wrStrb_ff    <= s_axi_wstrb[0]; // Registers live in byte lane 0 only
        wHeld_ff     <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (doWrite)
      begin
        awHeld_ff    <= 1'b0;
        wHeld_ff     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wrMapped ? `IFC_RESP_OKAY : `IFC_RESP_SLVERR;
      end
      if (s_axi_bvalid & s_axi_bready)
      begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read data select; command register reads back as zero
  // Unmapped offsets answer SLVERR and zero rather than alias a register
  always @*
  begin
    nxt_rdata = 8'h00;
    nxt_rresp = `IFC_RESP_OKAY;
    if (s_axi_araddr == `IFC_MODE_REG_THREE)
      nxt_rdata = modeReg_ff;
    else if (s_axi_araddr == `IFC_COMMAND_REG)
      nxt_rdata = 8'h00;
    else if (s_axi_araddr == `IFC_RESUME_CHAR_REG)
      nxt_rdata = resumeChar_ff;
    else if (s_axi_araddr == `IFC_PAUSE_CHAR_REG)
      nxt_rdata = pauseChar_ff;
    else if (s_axi_araddr == `IFC_FLOW_STATUS_REG)
      nxt_rdata = {3'h0, hostSendOn_ff | hostSendOff_ff, pauseOut_ff,
                   autoStop_ff | hostStop_ff, recogSeen_ff};
    else if (s_axi_araddr == `IFC_IRQ_MASK_REG)
      nxt_rdata = {3'h0, irqMask_ff};
    else if (s_axi_araddr == `IFC_IRQ_STATUS_REG)
      nxt_rdata = {3'h0, |recogSeen_ff, 4'h0};
    else if (s_axi_araddr == `IFC_BID_CONTROL_REG)
      nxt_rdata = {5'h00, bidCtl_ff};
    else
      nxt_rresp = `IFC_RESP_SLVERR;
  end

  // One read at a time; answer one cycle after the address is taken
  // A status read clears the recognition flags on its take edge
  always @(posedge clk)
  begin
    if (rst)
    begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `IFC_RESP_OKAY;
    end
    else if (rdTake)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= {24'h000000, nxt_rdata};
      s_axi_rresp   <= nxt_rresp;
    end
    else if (s_axi_rvalid & s_axi_rready)
    begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Receive side recognition
  // ----------------------------------------------------------------
  // Overrun characters are not recognised, so a lost pause
  // can never stop the transmitter behind software's back
  wire recogOn   = modeReg_ff[`IFC_MODE_RECOG];
  wire rxTaken   = rxCharValid & ~rxQueueFull;
  wire hitResume = rxTaken & recogOn & charHit(rxChar, resumeChar_ff);
  wire hitPause  = rxTaken & recogOn & charHit(rxChar, pauseChar_ff);
  // Errored flow characters are kept so software can see why the link stopped
  wire stripIt   = (hitResume | hitPause) & modeReg_ff[`IFC_MODE_STRIP]
                   & (rxCharErr == 3'h0);

  // Pass received characters on, with their error bits, unless stripped
  // Char and error bits register every cycle; the strobe qualifies them
  always @(posedge clk)
  begin
    if (rst)
    begin
      rxStoreValid <= 1'b0;
      rxStoreChar  <= 8'h00;
      rxStoreErr   <= 3'h0;
    end
    else
    begin
      rxStoreValid <= rxTaken & ~stripIt;
      rxStoreChar  <= rxChar;
      rxStoreErr   <= rxCharErr;
    end
  end

  // ----------------------------------------------------------------
  // Transmit insertion and arbitration
  // ----------------------------------------------------------------
  // Auto requests are live terms, so a vanished fill condition cancels them
  // Thresholds are strict: fill 240 and fill 16 request nothing
  wire autoOff  = autoRx & (rxQueueFill > `IFC_FILL_HIGH) & ~pauseOut_ff;
  wire autoOn   = autoRx & (rxQueueFill < `IFC_FILL_LOW) & pauseOut_ff;
  // Host and auto requests merge; host ones wait for the shift register
  wire wantOff  = autoOff | hostSendOff_ff;
  wire wantOn   = autoOn | hostSendOn_ff;
  // Wait one cycle after a load so the shift register can report busy
  // Costs one idle cycle per character but rules out a double load
  wire canLoad  = txShiftEmpty & ~txLoadValid & txEnable_ff;
  // Flow characters bypass the pause stop so two paused ends cannot deadlock
  // Pause beats resume when both are wanted, keeping the far end safe
  wire sendOff  = canLoad & wantOff;
  wire sendOn   = canLoad & ~wantOff & wantOn;
  wire dataHeld = autoStop_ff | hostStop_ff;
  wire sendData = canLoad & ~wantOff & ~wantOn & ~dataHeld & txQueueValid;

  // ----------------------------------------------------------------
  // Control registers and flow state
  // ----------------------------------------------------------------
  // Software reset shares this path but not the bus, so the
  // command write that caused it still gets its response
  // The reset pulse is the only way this block flushes the queue
  always @(posedge clk)
  begin
    if (rst | softReset)
    begin
      modeReg_ff     <= `IFC_MODE_RST;
      resumeChar_ff  <= `IFC_RESUME_RST;
      pauseChar_ff   <= `IFC_PAUSE_RST;
      irqMask_ff     <= 5'h00;
      bidCtl_ff      <= 3'h0;
      recogSeen_ff   <= 2'h0;
      txEnable_ff    <= 1'b0;
      autoStop_ff    <= 1'b0;
      hostStop_ff    <= 1'b0;
      pauseOut_ff    <= 1'b0;
      hostSendOn_ff  <= 1'b0;
      hostSendOff_ff <= 1'b0;
      txLoadValid    <= 1'b0;
      txLoadChar     <= 8'h00;
      txQueuePop     <= 1'b0;
      txReset        <= softReset;
      recogBid       <= 1'b0;
      recogBidLevel  <= 3'h0;
    end
    else
    begin
      txReset <= 1'b0;
      // Register writes
      // Unmapped or lane-masked writes match nothing and change nothing
      if (regWrite & (wrAddr_ff == `IFC_MODE_REG_THREE))
      begin
        modeReg_ff <= wrData_ff;
        if (wrData_ff[`IFC_MODE_AUTORX:`IFC_MODE_AUTOTX] == 2'h0)
          pauseOut_ff <= 1'b0;
      end
      if (regWrite & (wrAddr_ff == `IFC_RESUME_CHAR_REG))
        resumeChar_ff <= wrData_ff;
      if (regWrite & (wrAddr_ff == `IFC_PAUSE_CHAR_REG))
        pauseChar_ff <= wrData_ff;
      if (regWrite & (wrAddr_ff == `IFC_IRQ_MASK_REG))
        irqMask_ff <= wrData_ff[4:0];
      if (regWrite & (wrAddr_ff == `IFC_BID_CONTROL_REG))
        bidCtl_ff <= wrData_ff[2:0];
      // Transmitter commands; ignored while auto transmit owns the transmitter
      // Host pause is still taken in auto receive, where the host owns data
      if (cmdWrite & ~autoTx)
      begin
        if (cmdCode == `IFC_CMD_TXEN)
          txEnable_ff <= 1'b1; // Re-enable does not lift a host pause
        if (cmdCode == `IFC_CMD_TXDIS)
          txEnable_ff <= 1'b0;
        if (cmdCode == `IFC_CMD_PAUSE)
          hostStop_ff <= 1'b1;
        if (cmdCode == `IFC_CMD_RESUME)
          hostStop_ff <= 1'b0;
      end
      // Auto transmit stop and restart; resume never lifts a host pause
      // Leaving auto transmit keeps a stop; only a resume received in auto transmit, or reset, clears it
      if (autoTx & hitPause)
        autoStop_ff <= 1'b1;
      else if (autoTx & hitResume)
        autoStop_ff <= 1'b0;
      // Recognition flags: read clears, a new hit in the same cycle wins
      // Flags record hits in every flow mode, so they work as detectors
      if (statusRd)
        recogSeen_ff <= 2'h0;
      if (hitResume)
        recogSeen_ff[`IFC_ST_RESUME] <= 1'b1;
      if (hitPause)
        recogSeen_ff[`IFC_ST_PAUSE] <= 1'b1;
      // Bid comes only from recognition, never from transmitter activity
      recogBid      <= (|recogSeen_ff | hitResume | hitPause)
                       & irqMask_ff[`IFC_IRQ_BIT] & ~statusRd;
      // Level follows the bid register every cycle, alongside the bid
      recogBidLevel <= bidCtl_ff;
      // Load the shift register: flow characters first, then queued data
      // A loaded character is never withdrawn; only the reset pulse stops it
      txLoadValid <= sendOff | sendOn | sendData;
      txQueuePop  <= sendData;
      if (sendOff)
      begin
        txLoadChar     <= pauseChar_ff;
        pauseOut_ff    <= 1'b1;
        hostSendOff_ff <= 1'b0;
      end
      else if (sendOn)
      begin
        txLoadChar    <= resumeChar_ff;
        pauseOut_ff   <= 1'b0;
        hostSendOn_ff <= 1'b0;
      end
      else if (sendData)
        txLoadChar <= txQueueData;
      // Host requests come last so a new command beats the load clear
      // Host flow character requests and cancel, host mode only
      if (cmdWrite & hostMode)
      begin
        if (cmdCode == `IFC_CMD_SENDON)
          hostSendOn_ff <= 1'b1;
        if (cmdCode == `IFC_CMD_SENDOFF)
          hostSendOff_ff <= 1'b1;
        if (cmdCode == `IFC_CMD_KILL)
        begin
          hostSendOn_ff  <= 1'b0;
          hostSendOff_ff <= 1'b0;
        end
      end
    end
  end

endmodule // ifc_flow

// ===== test/ifc_flow_sva.sv
// Purpose: Concurrent checks on the ports of ifc_flow
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound into every ifc_flow instance
`timescale 1ns/1ps

module ifc_flow_sva (
  input logic       clk,
  input logic       rst,
  input logic       rxCharValid,
  input logic [7:0] rxChar,
  input logic [2:0] rxCharErr,
  input logic       rxQueueFull,
  input logic       rxStoreValid,
  input logic [7:0] rxStoreChar,
  input logic [2:0] rxStoreErr,
  input logic       txQueueValid,
  input logic [7:0] txQueueData,
  input logic       txShiftEmpty,
  input logic       txQueuePop,
  input logic       txLoadValid,
  input logic [7:0] txLoadChar,
  input logic       txReset
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  // Overrun character and the one-cycle load strobe
  sequence s_overrun;
    rxCharValid && rxQueueFull;
  endsequence
  sequence s_load;
    txLoadValid ##1 !txLoadValid;
  endsequence

  a_store_cause: assert property (rxStoreValid |-> $past(rxCharValid) && !$past(rxQueueFull))
    else $error("store without an accepted character");
  a_store_data: assert property (rxStoreValid |-> rxStoreChar == $past(rxChar) && rxStoreErr == $past(rxCharErr))
    else $error("stored character or error bits altered");
  a_overrun_drop: assert property (s_overrun |=> !rxStoreValid)
    else $error("overrun character was stored");
  a_pop_data: assert property (txQueuePop |-> txLoadValid && $past(txQueueValid) && txLoadChar == $past(txQueueData))
    else $error("queued data not loaded unchanged");
  a_load_empty: assert property (txLoadValid |-> $past(txShiftEmpty))
    else $error("load while shift register busy");
  a_load_gap: assert property (txLoadValid |-> s_load)
    else $error("back to back loads");
  a_txrst_pulse: assert property (txReset |=> !txReset)
    else $error("transmitter reset longer than one cycle");
  a_reset_idle: assert property ($fell(rst) |-> !txLoadValid && !rxStoreValid && !txReset)
    else $error("outputs active right after reset");
endmodule // ifc_flow_sva

bind ifc_flow ifc_flow_sva i_sva (.clk, .rst, .rxCharValid, .rxChar, .rxCharErr, .rxQueueFull,
  .rxStoreValid, .rxStoreChar, .rxStoreErr, .txQueueValid, .txQueueData, .txShiftEmpty,
  .txQueuePop, .txLoadValid, .txLoadChar, .txReset);

// ===== test/ifc_far_model.sv
// Purpose: Transmit queue and shift register beside ifc_flow
// Assumes: Shift register busy for ten cycles per character
// Notes:   Logs every loaded character in sentQ
`timescale 1ns/1ps

module ifc_far_model (
  input  logic       clk,
  input  logic       rst,
  input  logic       txLoadValid,
  input  logic [7:0] txLoadChar,
  input  logic       txQueuePop,
  input  logic       txReset,
  output logic       txShiftEmpty,
  output logic       txQueueValid,
  output logic [7:0] txQueueData
);
  logic [7:0] txq[$];
  logic [7:0] sentQ[$];
  int         busy;
  logic [7:0] lastData;

  // Bench writes land here even while the transmitter is held
  task automatic push(input logic [7:0] d);
    txq.push_back(d);
  endtask

  // Head is registered so the block never sees a half-updated queue
  always @(posedge clk)
  begin
    if (rst || txReset)
    begin
      txq.delete();
      busy <= 0;
    end
    else
    begin
      if (busy > 0)
        busy <= busy - 1;
      if (txLoadValid)
      begin
        sentQ.push_back(txLoadChar);
        busy <= 10;
      end
      if (txQueuePop && txq.size() > 0)
      begin
        lastData <= txq[0];
        void'(txq.pop_front());
      end
    end
    txQueueValid <= txq.size() > 0;
    // An empty queue shows no stale head byte
    txQueueData  <= txq.size() > 0 ? txq[0] : ~lastData;
  end
  always @(posedge clk)
    txShiftEmpty <= (busy <= 1) && !txLoadValid;
endmodule // ifc_far_model

// ===== test/tb_ifc_flow.sv
// Purpose: Self-checking bench for ifc_flow
// Assumes: ifc_far_model stands in for queue and shift register
// Notes:   Registers reached only through AXI4-Lite tasks
`timescale 1ns/1ps
`include "ifc_flow_regs.vh"

module tb_ifc_flow;
  logic        clk, rst;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, br;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic        rxCharValid, rxQueueFull, rxStoreValid, txQueueValid, txShiftEmpty;
  logic [7:0]  rxChar, rxStoreChar, txQueueData, txLoadChar, d;
  logic [2:0]  rxCharErr, rxStoreErr, recogBidLevel;
  logic [8:0]  rxQueueFill;
  logic        txQueuePop, txLoadValid, txReset, recogBid;
  int          n_mismatch, tests_run;

  ifc_flow i_dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .rxCharValid, .rxChar, .rxCharErr, .rxQueueFull, .rxQueueFill,
    .rxStoreValid, .rxStoreChar, .rxStoreErr, .txQueueValid, .txQueueData, .txShiftEmpty,
    .txQueuePop, .txLoadValid, .txLoadChar, .txReset, .recogBid, .recogBidLevel);
  ifc_far_model i_far (.clk, .rst, .txLoadValid, .txLoadChar, .txQueuePop, .txReset,
    .txShiftEmpty, .txQueueValid, .txQueueData);

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("Mismatches %0d, comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Each channel is released on its own ready
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    br = s_axi_bresp;
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata[7:0];
    chk(s_axi_rresp, er);
  endtask
  task automatic cmd(input logic [4:0] c);
    wr(`IFC_COMMAND_REG, {c, 3'h0});
  endtask
  // One received character; judges whether it reached the queue
  task automatic rxc(input logic [7:0] c, input logic [2:0] e, input logic full, input logic st);
    rxCharValid <= 1'b1;
    rxChar <= c;
    rxCharErr <= e;
    rxQueueFull <= full;
    @(posedge clk);
    rxCharValid <= 1'b0;
    rxQueueFull <= 1'b0;
    @(posedge clk);
    chk(rxStoreValid, st);
  endtask
  task automatic txExp(input logic [7:0] c);
    int k;
    k = 0;
    while (i_far.sentQ.size() == 0 && k < 60)
    begin
      @(posedge clk);
      k++;
    end
    if (k == 60)
      chk(32'h0000dead, c);
    else
      chk(i_far.sentQ.pop_front(), c);
  endtask
  task automatic txNone;
    repeat (40) @(posedge clk);
    chk(i_far.sentQ.size(), 0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rd(`IFC_RESUME_CHAR_REG, `IFC_RESP_OKAY); chk(d, 8'h11);
    rd(`IFC_PAUSE_CHAR_REG, `IFC_RESP_OKAY); chk(d, 8'h13);
    rd(8'h40, `IFC_RESP_SLVERR);
    wr(8'h40, 8'h00);
    chk(br, `IFC_RESP_SLVERR);
  endtask
  task automatic t_recog;
    wr(`IFC_MODE_REG_THREE, 8'h10);
    wr(`IFC_IRQ_MASK_REG, 8'h10);
    wr(`IFC_BID_CONTROL_REG, 8'h05);
    rxc(8'h13, 3'h0, 1'b0, 1'b1);
    chk(recogBid, 1'b1);
    chk(recogBidLevel, 3'h5);
    rd(`IFC_IRQ_STATUS_REG, `IFC_RESP_OKAY); chk(d[4], 1'b1);
    rd(`IFC_FLOW_STATUS_REG, `IFC_RESP_OKAY); chk(d[1], 1'b1);
    rd(`IFC_FLOW_STATUS_REG, `IFC_RESP_OKAY); chk(d[1], 1'b0);
    rxc(8'h13, 3'h0, 1'b1, 1'b0);
    rd(`IFC_FLOW_STATUS_REG, `IFC_RESP_OKAY); chk(d[1], 1'b0);
    wr(`IFC_MODE_REG_THREE, 8'h90);
    rxc(8'h11, 3'h0, 1'b0, 1'b0);
    rxc(8'h11, 3'h4, 1'b0, 1'b1);
    wr(`IFC_MODE_REG_THREE, 8'h10);
    wr(`IFC_IRQ_MASK_REG, 8'h00);
    rxc(8'h13, 3'h0, 1'b0, 1'b1);
    chk(recogBid, 1'b0);
  endtask
  task automatic t_autotx;
    cmd(`IFC_CMD_TXEN); // Enable first: auto transmit ignores commands
    wr(`IFC_MODE_REG_THREE, 8'h14);
    cmd(`IFC_CMD_TXDIS);
    i_far.push(8'ha1);
    txExp(8'ha1);
    rxc(8'h13, 3'h0, 1'b0, 1'b1);
    i_far.push(8'ha2);
    cmd(`IFC_CMD_RESUME);
    txNone();
    rxc(8'h11, 3'h0, 1'b0, 1'b1);
    txExp(8'ha2);
  endtask
  task automatic t_host;
    wr(`IFC_MODE_REG_THREE, 8'h10);
    cmd(`IFC_CMD_PAUSE);
    i_far.push(8'hb1);
    rxc(8'h11, 3'h0, 1'b0, 1'b1);
    cmd(`IFC_CMD_TXDIS);
    cmd(`IFC_CMD_TXEN);
    txNone();
    cmd(`IFC_CMD_RESUME);
    txExp(8'hb1);
    cmd(`IFC_CMD_SENDOFF);
    txExp(8'h13);
    cmd(`IFC_CMD_SENDON);
    txExp(8'h11);
    cmd(`IFC_CMD_TXDIS);
    cmd(`IFC_CMD_SENDOFF);
    cmd(`IFC_CMD_KILL);
    cmd(`IFC_CMD_TXEN);
    txNone();
  endtask
  task automatic t_autorx(input logic [7:0] m);
    wr(`IFC_MODE_REG_THREE, 8'h10);
    wr(`IFC_MODE_REG_THREE, m);
    rxQueueFill <= 9'd240;
    txNone();
    rxQueueFill <= 9'd241;
    txExp(8'h13);
    rxQueueFill <= 9'd16;
    txNone();
    rxQueueFill <= 9'd15;
    txExp(8'h11);
    rxQueueFill <= 9'd100;
    if (!m[`IFC_MODE_AUTOTX])
    begin
      cmd(`IFC_CMD_TXDIS);
      rxQueueFill <= 9'd241;
      repeat (5) @(posedge clk);
      rxQueueFill <= 9'd100;
      cmd(`IFC_CMD_TXEN);
      txNone();
    end
  endtask
  task automatic t_swreset;
    wr(`IFC_MODE_REG_THREE, 8'h10);
    wr(`IFC_RESUME_CHAR_REG, 8'h5a);
    cmd(`IFC_CMD_PAUSE);
    i_far.push(8'hc1);
    cmd(`IFC_CMD_RESET);
    repeat (3) @(posedge clk);
    chk(i_far.txq.size(), 0);
    rd(`IFC_RESUME_CHAR_REG, `IFC_RESP_OKAY); chk(d, 8'h11);
    rxc(8'h13, 3'h0, 1'b0, 1'b1);
    rd(`IFC_FLOW_STATUS_REG, `IFC_RESP_OKAY); chk(d[1], 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Clock, stimulus and watchdog
  // ----------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial
  begin
    {rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h21;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hf;
    {rxCharValid, rxQueueFull, rxChar, rxCharErr} = 13'h0;
    rxQueueFill = 9'd100;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_recog();
    t_autotx();
    t_host();
    t_autorx(8'h18);
    t_autorx(8'h1c);
    t_swreset();
    results();
  end
  // Whole run needs under a thousand cycles
  initial
  begin
    #400000;
    n_mismatch++;
    results();
  end
endmodule // tb_ifc_flow
